//--- hdl/ppm_pkg.sv
package ppm_pkg;
    localparam int PORT_CNT = 7;
    localparam int IRQ_CNT  = 6;
    localparam int ALT_W    = 12;

    // Port slots: P0, P1, P2, P3, P7, P8, P9
    localparam int PX_0 = 0;
    localparam int PX_1 = 1;
    localparam int PX_2 = 2;
    localparam int PX_3 = 3;
    localparam int PX_7 = 4;
    localparam int PX_8 = 5;
    localparam int PX_9 = 6;

    // Bits that may be steered to output
    localparam logic [PORT_CNT-1:0][7:0] DIR_MASK =
        {8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'h3e};
    // Bits that exist as pins
    localparam logic [PORT_CNT-1:0][7:0] PIN_MASK =
        {8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'hbf};

    // Register byte offsets; port slot n sits at n*4
    localparam logic [7:0] OFS_PORT_LAST = 8'h18;
    localparam logic [7:0] OFS_ALT_EN    = 8'h20;
    localparam logic [7:0] OFS_LCD_CTRL  = 8'h24;
    localparam logic [7:0] OFS_EDGE_CFG  = 8'h28;
    localparam logic [7:0] OFS_IRQ_STS   = 8'h2c;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h30;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h34;

    // Port register fields
    localparam int FLD_LATCH = 0;
    localparam int FLD_DIR   = 8;
    localparam int FLD_PU    = 16;
    localparam int FLD_PIN   = 24;

    // Alternate function enable bits
    localparam int ALT_WT_OUT   = 0;
    localparam int ALT_BTA_OUT  = 1;
    localparam int ALT_BTB_OUT  = 2;
    localparam int ALT_PCLK     = 3;
    localparam int ALT_BUZ      = 4;
    localparam int ALT_S0_OUT   = 5;
    localparam int ALT_S0_CLK   = 6;
    localparam int ALT_S0_BUS   = 7;
    localparam int ALT_S2_OUT   = 8;
    localparam int ALT_S2_CLK   = 9;
    localparam int ALT_S2_ASYNC = 10;
    localparam int ALT_ADC      = 11;

    // Edge selection codes, two bits per interrupt input
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    localparam logic [ALT_W-1:0]     ALT_RST  = 12'h000;
    localparam logic [7:0]           LCD_RST  = 8'h00;
    localparam logic [2*IRQ_CNT-1:0] EDGE_RST = 12'h000;

    typedef struct packed {
        logic [PORT_CNT-1:0][7:0] latch;
        logic [PORT_CNT-1:0][7:0] out_en;
        logic [PORT_CNT-1:0][7:0] pu;
        logic [ALT_W-1:0]         alt_en;
        logic [7:0]               lcd_sel;
        logic [2*IRQ_CNT-1:0]     edge_cfg;
        logic [IRQ_CNT-1:0]       irq_sts;
        logic [IRQ_CNT-1:0]       irq_en;
        logic [PORT_CNT-1:0][7:0] pin_out;
        logic [PORT_CNT-1:0][7:0] pin_oe;
        logic [PORT_CNT-1:0][7:0] pin_pu;
        logic [PORT_CNT-1:0][7:0] pin_lvl;
        logic [31:0]              prdata;
        logic [23:0]              seg;
        logic [3:0]               com;
    } ppm_state_s;

    typedef struct packed {
        logic                 armed;
        logic [IRQ_CNT-1:0]   prev;
        logic [IRQ_CNT-1:0]   hit;
    } ppm_edge_s;
endpackage

//--- hdl/ppm_edge_if.sv
`timescale 1ns/100ps
interface ppm_edge_if;
    logic [5:0]  level;
    logic [11:0] cfg;
    logic [5:0]  hit;
    modport src (output level, output cfg, input hit);
    modport det (input level, input cfg, output hit);
endinterface

//--- hdl/ppm_edge_det.sv
`timescale 1ns/100ps
module ppm_edge_det (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    ppm_edge_if.det   e
);
    import ppm_pkg::*;

    ppm_edge_s st_r;
    ppm_edge_s st_nxt;

    // First cycle after reset only samples, so a pin already high is no edge
    always_comb begin
        st_nxt       = st_r;
        st_nxt.armed = 1'b1;
        st_nxt.prev  = e.level;
        for (int k = 0; k < IRQ_CNT; k++) begin
            logic rise;
            logic fall;
            rise = e.level[k] & ~st_r.prev[k];
            fall = ~e.level[k] & st_r.prev[k];
            if (!st_r.armed) begin
                st_nxt.hit[k] = 1'b0;
            end else if (e.cfg[2*k +: 2] == EDGE_RISE) begin
                st_nxt.hit[k] = rise; // [R10]
            end else if (e.cfg[2*k +: 2] == EDGE_FALL) begin
                st_nxt.hit[k] = fall; // [R10]
            end else begin
                st_nxt.hit[k] = rise | fall; // [R10]
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign e.hit = st_r.hit;
endmodule

//--- hdl/ppm_top.sv
`timescale 1ns/100ps
//
// Contract
// [R1] Port 0: bits 0-5,7; 0 and 7 input-only
// [R2] Per-bit direction on all bidirectional bits
// [R3] Pull-up acts only on input bits
// [R4] Reset: all inputs, alternates off, LCD excepted
// [R5] Software sets feedback cut before P07 input
// [R6] Analog mode forces port 1 input, no pull-ups
// [R7] Ports 8, 9: segment select per pin pair
// [R8] Segments 0-23 dedicated; 24-39 on ports 9, 8
// [R9] Four dedicated common outputs drive from reset
// [R10] Six interrupts: rising, falling or both edges
// [R11] P00 wide timer count, P01 capture trigger
// [R12] P33, P34 byte timer count inputs
// [R13] P30-P32 driven by timer outputs
// [R14] Serial 0 data/bus lines on P25, P26
// [R15] Serial clock pins bidirectional, master drives
// [R16] Serial 2 on P70-P72, async baud input
// [R17] P35 clock out, P36 buzzer, P37 none
// [R18] Software avoids port writes during conversion
// [R19] Alternate output overrides latch; reads show pin
module ppm_top (
    input  wire logic                                         i_ref_clk,
    input  wire logic                                         i_rst_n,
    input  wire logic                                         psel,
    input  wire logic                                         penable,
    input  wire logic                                         pwrite,
    input  wire logic [7:0]                                   paddr,
    input  wire logic [31:0]                                  pwdata,
    output logic                                              pready,
    output logic                                              pslverr,
    output logic      [31:0]                                  prdata,
    output logic                                              o_irq,
    input  wire logic [ppm_pkg::PORT_CNT-1:0][7:0]            i_port_pin,
    output logic      [ppm_pkg::PORT_CNT-1:0][7:0]            o_port_pin,
    output logic      [ppm_pkg::PORT_CNT-1:0][7:0]            o_port_oe,
    output logic      [ppm_pkg::PORT_CNT-1:0][7:0]            o_port_pullup,
    output logic      [5:0]                                   o_ext_irq_inputs,
    output logic                                              o_wide_timer_count_in,
    output logic                                              o_wide_timer_capture_in,
    output logic                                              o_byte_timer_a_count_in,
    output logic                                              o_byte_timer_b_count_in,
    input  wire logic                                         i_wide_timer_out,
    input  wire logic                                         i_byte_timer_a_out,
    input  wire logic                                         i_byte_timer_b_out,
    input  wire logic                                         i_prog_clock_out,
    input  wire logic                                         i_buzzer_out,
    output logic                                              o_ser0_data_in,
    output logic                                              o_ser0_bus_line_b_in,
    output logic                                              o_ser0_clock_pin_in,
    input  wire logic                                         i_ser0_data_out,
    input  wire logic                                         i_ser0_clock_pin_out,
    input  wire logic                                         i_ser0_bus_line_a_low,
    input  wire logic                                         i_ser0_bus_line_b_low,
    output logic                                              o_ser2_data_in,
    output logic                                              o_ser2_clock_pin_in,
    output logic                                              o_async_baud_clock_in,
    input  wire logic                                         i_ser2_data_out,
    input  wire logic                                         i_ser2_clock_pin_out,
    output logic                                              o_analog_mode,
    input  wire logic [39:0]                                  i_lcd_segment_outputs,
    input  wire logic [3:0]                                   i_lcd_common_outputs,
    output logic      [23:0]                                  o_lcd_segment_outputs,
    output logic      [3:0]                                   o_lcd_common_outputs
);
    import ppm_pkg::*;

    ppm_state_s st_r;
    ppm_state_s st_nxt;
    ppm_edge_if edge_bus ();

    // Port slot of an address, or PORT_CNT when it is not a port register
    function automatic logic [2:0] port_slot(input logic [7:0] a);
        if (a[1:0] == 2'h0 && a <= OFS_PORT_LAST) begin
            port_slot = a[4:2];
        end else begin
            port_slot = 3'(PORT_CNT);
        end
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        if (port_slot(a) != 3'(PORT_CNT)) begin
            addr_ok = 1'b1;
        end else if (a == OFS_ALT_EN || a == OFS_LCD_CTRL || a == OFS_EDGE_CFG) begin
            addr_ok = 1'b1;
        end else if (a == OFS_IRQ_STS || a == OFS_IRQ_CLR || a == OFS_IRQ_EN) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    endfunction

    assign edge_bus.level = i_port_pin[PX_0][5:0];
    assign edge_bus.cfg   = st_r.edge_cfg;

    ppm_edge_det u_edge (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .e         (edge_bus)
    );

    logic       wr_acc;
    logic       rd_setup;
    logic [2:0] slot;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign slot     = port_slot(paddr);

    always_comb begin
        st_nxt = st_r;

        // Register writes take effect at the access edge
        if (wr_acc) begin
            if (slot != 3'(PORT_CNT)) begin
                st_nxt.latch[slot]  = pwdata[FLD_LATCH +: 8] & DIR_MASK[slot];
                st_nxt.out_en[slot] = pwdata[FLD_DIR +: 8] & DIR_MASK[slot]; // [R2] [R1]
                st_nxt.pu[slot]     = pwdata[FLD_PU +: 8] & DIR_MASK[slot];
            end else if (paddr == OFS_ALT_EN) begin
                st_nxt.alt_en = pwdata[ALT_W-1:0];
            end else if (paddr == OFS_LCD_CTRL) begin
                st_nxt.lcd_sel = pwdata[7:0];
            end else if (paddr == OFS_EDGE_CFG) begin
                st_nxt.edge_cfg = pwdata[2*IRQ_CNT-1:0];
            end else if (paddr == OFS_IRQ_EN) begin
                st_nxt.irq_en = pwdata[IRQ_CNT-1:0];
            end
        end

        // Clear first, then set, so an edge in the clear cycle survives
        if (wr_acc && paddr == OFS_IRQ_CLR) begin
            st_nxt.irq_sts = st_r.irq_sts & ~pwdata[IRQ_CNT-1:0];
        end
        st_nxt.irq_sts = st_nxt.irq_sts | edge_bus.hit; // [R10]

        // Read data is captured in the setup cycle and held through access
        if (rd_setup) begin
            st_nxt.prdata = 32'h0;
            if (slot != 3'(PORT_CNT)) begin
                st_nxt.prdata[FLD_LATCH +: 8] = st_r.latch[slot];
                st_nxt.prdata[FLD_DIR +: 8]   = st_r.out_en[slot];
                st_nxt.prdata[FLD_PU +: 8]    = st_r.pu[slot];
                st_nxt.prdata[FLD_PIN +: 8]   = i_port_pin[slot] & PIN_MASK[slot]; // [R19]
            end else if (paddr == OFS_ALT_EN) begin
                st_nxt.prdata[ALT_W-1:0] = st_r.alt_en;
            end else if (paddr == OFS_LCD_CTRL) begin
                st_nxt.prdata[7:0] = st_r.lcd_sel;
            end else if (paddr == OFS_EDGE_CFG) begin
                st_nxt.prdata[2*IRQ_CNT-1:0] = st_r.edge_cfg;
            end else if (paddr == OFS_IRQ_STS) begin
                st_nxt.prdata[IRQ_CNT-1:0] = st_r.irq_sts;
            end else if (paddr == OFS_IRQ_EN) begin
                st_nxt.prdata[IRQ_CNT-1:0] = st_r.irq_en;
            end
        end

        // Port latch drives by default; masks keep input-only bits floating
        st_nxt.pin_out = st_r.latch;
        st_nxt.pin_oe  = st_r.out_en & DIR_MASK; // [R1] [R2]

        if (st_r.alt_en[ALT_WT_OUT]) begin
            st_nxt.pin_out[PX_3][0] = i_wide_timer_out; // [R13] [R19]
            st_nxt.pin_oe[PX_3][0]  = 1'b1;
        end
        if (st_r.alt_en[ALT_BTA_OUT]) begin
            st_nxt.pin_out[PX_3][1] = i_byte_timer_a_out; // [R13]
            st_nxt.pin_oe[PX_3][1]  = 1'b1;
        end
        if (st_r.alt_en[ALT_BTB_OUT]) begin
            st_nxt.pin_out[PX_3][2] = i_byte_timer_b_out; // [R13]
            st_nxt.pin_oe[PX_3][2]  = 1'b1;
        end
        if (st_r.alt_en[ALT_PCLK]) begin
            st_nxt.pin_out[PX_3][5] = i_prog_clock_out; // [R17]
            st_nxt.pin_oe[PX_3][5]  = 1'b1;
        end
        if (st_r.alt_en[ALT_BUZ]) begin
            st_nxt.pin_out[PX_3][6] = i_buzzer_out; // [R17]
            st_nxt.pin_oe[PX_3][6]  = 1'b1;
        end

        // Bus mode makes both serial 0 data pins open-drain lines
        if (st_r.alt_en[ALT_S0_BUS]) begin
            st_nxt.pin_out[PX_2][5] = 1'b0; // [R14]
            st_nxt.pin_oe[PX_2][5]  = i_ser0_bus_line_a_low;
            st_nxt.pin_out[PX_2][6] = 1'b0;
            st_nxt.pin_oe[PX_2][6]  = i_ser0_bus_line_b_low;
        end else if (st_r.alt_en[ALT_S0_OUT]) begin
            st_nxt.pin_out[PX_2][6] = i_ser0_data_out; // [R14]
            st_nxt.pin_oe[PX_2][6]  = 1'b1;
        end
        if (st_r.alt_en[ALT_S0_CLK]) begin
            st_nxt.pin_out[PX_2][7] = i_ser0_clock_pin_out; // [R15]
            st_nxt.pin_oe[PX_2][7]  = 1'b1;
        end
        if (st_r.alt_en[ALT_S2_OUT]) begin
            st_nxt.pin_out[PX_7][1] = i_ser2_data_out; // [R16]
            st_nxt.pin_oe[PX_7][1]  = 1'b1;
        end
        // Async mode wins over master clock: the pin only takes a baud clock
        if (st_r.alt_en[ALT_S2_ASYNC]) begin
            st_nxt.pin_oe[PX_7][2] = 1'b0; // [R16]
        end else if (st_r.alt_en[ALT_S2_CLK]) begin
            st_nxt.pin_out[PX_7][2] = i_ser2_clock_pin_out; // [R15]
            st_nxt.pin_oe[PX_7][2]  = 1'b1;
        end

        // Each select bit hands one pin pair to the segment driver
        for (int k = 0; k < 8; k++) begin
            if (st_r.lcd_sel[k]) begin // [R7]
                for (int j = 2*(k%4); j < 2*(k%4) + 2; j++) begin
                    if (k < 4) begin
                        st_nxt.pin_out[PX_9][j] = i_lcd_segment_outputs[31-j]; // [R8]
                        st_nxt.pin_oe[PX_9][j]  = 1'b1;
                    end else begin
                        st_nxt.pin_out[PX_8][j] = i_lcd_segment_outputs[39-j]; // [R8]
                        st_nxt.pin_oe[PX_8][j]  = 1'b1;
                    end
                end
            end
        end

        if (st_r.alt_en[ALT_ADC]) begin
            st_nxt.pin_oe[PX_1] = 8'h00; // [R6]
        end

        st_nxt.pin_pu = st_r.pu & ~st_nxt.pin_oe & DIR_MASK; // [R3]
        if (st_r.alt_en[ALT_ADC]) begin
            st_nxt.pin_pu[PX_1] = 8'h00; // [R6]
        end

        // Input routing is registered so every data output comes from a flop
        st_nxt.pin_lvl = i_port_pin & PIN_MASK;
        st_nxt.seg     = i_lcd_segment_outputs[23:0]; // [R8]
        st_nxt.com     = i_lcd_common_outputs; // [R9]
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_r         <= '0; // [R4]
            st_r.alt_en  <= ALT_RST;
            st_r.lcd_sel <= LCD_RST;
            st_r.edge_cfg <= EDGE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok(paddr);
    assign prdata  = st_r.prdata;
    assign o_irq   = |(st_r.irq_sts & st_r.irq_en);

    assign o_port_pin    = st_r.pin_out;
    assign o_port_oe     = st_r.pin_oe;
    assign o_port_pullup = st_r.pin_pu;

    assign o_ext_irq_inputs        = edge_bus.hit;
    assign o_wide_timer_count_in   = st_r.pin_lvl[PX_0][0]; // [R11]
    assign o_wide_timer_capture_in = st_r.pin_lvl[PX_0][1]; // [R11]
    assign o_byte_timer_a_count_in = st_r.pin_lvl[PX_3][3]; // [R12]
    assign o_byte_timer_b_count_in = st_r.pin_lvl[PX_3][4]; // [R12]
    assign o_ser0_data_in          = st_r.pin_lvl[PX_2][5]; // [R14]
    assign o_ser0_bus_line_b_in    = st_r.pin_lvl[PX_2][6]; // [R14]
    assign o_ser0_clock_pin_in     = st_r.pin_lvl[PX_2][7]; // [R15]
    assign o_ser2_data_in          = st_r.pin_lvl[PX_7][0]; // [R16]
    assign o_ser2_clock_pin_in     = st_r.pin_lvl[PX_7][2]; // [R15]
    assign o_async_baud_clock_in   = st_r.pin_lvl[PX_7][2]; // [R16]
    assign o_analog_mode           = st_r.alt_en[ALT_ADC];
    assign o_lcd_segment_outputs   = st_r.seg;
    assign o_lcd_common_outputs    = st_r.com;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_reset_inputs;
        $past(!i_rst_n) |-> (o_port_oe == '0) && (o_port_pullup == '0);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pin driven after reset"); // [R4]

    property p_p0_input_only;
        !o_port_oe[PX_0][0] && !o_port_oe[PX_0][6] && !o_port_oe[PX_0][7];
    endproperty
    a_p0_input_only: assert property (p_p0_input_only) else $error("P0 input bit driven"); // [R1]

    property p_pullup_input;
        (o_port_pullup & o_port_oe) == '0;
    endproperty
    a_pullup_input: assert property (p_pullup_input) else $error("pull-up on output"); // [R3]

    property p_adc_port1;
        st_r.alt_en[ALT_ADC] |=> (o_port_pullup[PX_1] == 8'h00) && (o_port_oe[PX_1] == 8'h00);
    endproperty
    a_adc_port1: assert property (p_adc_port1) else $error("port 1 not released"); // [R6]

    property p_edge_sets_status;
        (edge_bus.hit != 6'h00) |=> ((st_r.irq_sts & $past(edge_bus.hit)) == $past(edge_bus.hit));
    endproperty
    a_edge_sets_status: assert property (p_edge_sets_status) else $error("edge lost"); // [R10]

    property p_timer_out;
        st_r.alt_en[ALT_WT_OUT] |=> o_port_oe[PX_3][0] && (o_port_pin[PX_3][0] == $past(i_wide_timer_out));
    endproperty
    a_timer_out: assert property (p_timer_out) else $error("timer output not on pin"); // [R13]

    property p_lcd_pair;
        st_r.lcd_sel[0] |=> o_port_oe[PX_9][1] && (o_port_pin[PX_9][1] == $past(i_lcd_segment_outputs[30]));
    endproperty
    a_lcd_pair: assert property (p_lcd_pair) else $error("segment not on port 9"); // [R7]

    property p_count_in;
        1'b1 |=> o_wide_timer_count_in == $past(i_port_pin[PX_0][0]);
    endproperty
    a_count_in: assert property (p_count_in) else $error("count input not routed"); // [R11]

    property p_common;
        1'b1 |=> o_lcd_common_outputs == $past(i_lcd_common_outputs);
    endproperty
    a_common: assert property (p_common) else $error("common output stale"); // [R9]

    property p_irq_level;
        ((st_r.irq_sts & st_r.irq_en) != 6'h00) |-> o_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq low with pending"); // [R10]

    c_edge_hit: cover property (edge_bus.hit != 6'h00);
    c_lcd_sel:  cover property (st_r.lcd_sel != 8'h00);
    c_adc_mode: cover property (st_r.alt_en[ALT_ADC] && (st_r.pu[PX_1] != 8'h00));
    c_s0_bus:   cover property (st_r.alt_en[ALT_S0_BUS] && o_port_oe[PX_2][5]);
endmodule

//--- tb/ppm_board_model.sv
`timescale 1ns/100ps
module ppm_board_model (
    input  wire logic [6:0][7:0] i_drv,
    input  wire logic [6:0][7:0] i_oe,
    input  wire logic [6:0][7:0] i_pu,
    input  wire logic [6:0][7:0] i_ext,
    output logic      [6:0][7:0] o_lvl
);
    // Undriven, unpulled bits follow the board; random board levels keep stale values out
    always_comb begin
        o_lvl = (i_drv & i_oe) | (~i_oe & i_pu) | (~i_oe & ~i_pu & i_ext);
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ppm_pkg::*;
    logic            i_ref_clk = 1'b0;
    logic            i_rst_n = 1'b0;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, q, sd = 32'h5e102503;
    logic            pready, pslverr, o_irq, o_analog_mode, er;
    logic [6:0][7:0] i_port_pin, o_port_pin, o_port_oe, o_port_pullup, ext = '0;
    logic [5:0]      o_ext_irq_inputs, sio = 6'h00;
    logic [4:0]      tmo = 5'h00;
    logic            o_wide_timer_count_in, o_wide_timer_capture_in, o_byte_timer_a_count_in;
    logic            o_byte_timer_b_count_in, o_ser0_data_in, o_ser0_bus_line_b_in;
    logic            o_ser0_clock_pin_in, o_ser2_data_in, o_ser2_clock_pin_in;
    logic            o_async_baud_clock_in;
    logic [39:0]     i_lcd_segment_outputs = '0;
    logic [3:0]      i_lcd_common_outputs = 4'h0, o_lcd_common_outputs;
    logic [23:0]     o_lcd_segment_outputs;
    int              num_errors = 0, check_count = 0, cyc = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    ppm_board_model u_brd (.i_drv(o_port_pin), .i_oe(o_port_oe), .i_pu(o_port_pullup),
        .i_ext(ext), .o_lvl(i_port_pin));

    ppm_top u_dut (.i_ref_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .o_irq, .i_port_pin, .o_port_pin, .o_port_oe, .o_port_pullup,
        .o_ext_irq_inputs, .o_wide_timer_count_in, .o_wide_timer_capture_in,
        .o_byte_timer_a_count_in, .o_byte_timer_b_count_in, .i_wide_timer_out(tmo[0]),
        .i_byte_timer_a_out(tmo[1]), .i_byte_timer_b_out(tmo[2]), .i_prog_clock_out(tmo[3]),
        .i_buzzer_out(tmo[4]), .o_ser0_data_in, .o_ser0_bus_line_b_in, .o_ser0_clock_pin_in,
        .i_ser0_data_out(sio[0]), .i_ser0_clock_pin_out(sio[1]),
        .i_ser0_bus_line_a_low(sio[2]), .i_ser0_bus_line_b_low(sio[3]), .o_ser2_data_in,
        .o_ser2_clock_pin_in, .o_async_baud_clock_in, .i_ser2_data_out(sio[4]),
        .i_ser2_clock_pin_out(sio[5]), .o_analog_mode, .i_lcd_segment_outputs,
        .i_lcd_common_outputs, .o_lcd_segment_outputs, .o_lcd_common_outputs);

    function automatic logic [31:0] rnd();
        sd = {sd[30:0], ^(sd & 32'h80200003)};
        return sd;
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_ref_clk);
        penable <= 1'b1;
        do @(posedge i_ref_clk); while (pready !== 1'b1);
        q  = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Checks land on the falling edge, clear of the registers' update
    task automatic nap(input int n);
        repeat (n) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        logic [31:0]     r;
        logic [6:0][7:0] l, d, p;
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        r = rnd();
        sio <= r[5:0];
        i_lcd_common_outputs <= r[3:0];
        i_lcd_segment_outputs <= {r[7:0], r};
        nap(1);
        chk("oe", 64'h0, o_port_oe);
        chk("pullup", 64'h0, o_port_pullup);
        chk("com", r[3:0], o_lcd_common_outputs);
        chk("seg", r[23:0], o_lcd_segment_outputs);
        $display("reset test done");
        repeat (3) begin
            for (int s = 0; s < 7; s++) begin
                r = rnd();
                {p[s], d[s], l[s]} = r[23:0];
                apb(1'b1, 8'(4*s), r);
            end
            r = rnd();
            @(posedge i_ref_clk);
            // Board level on the shared crystal pin assumes the feedback cut is set
            ext <= {r[23:0], r};
            nap(2);
            chk("dir", DIR_MASK & d, o_port_oe);
            chk("drive", DIR_MASK & d & l, o_port_oe & o_port_pin);
            chk("pullup", DIR_MASK & p & ~d, o_port_pullup);
            apb(1'b0, 8'h00, 32'h0);
            chk("p0 dir", d[0] & 8'h3e, q[15:8]);
        end
        $display("direction test done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h0c, 32'h0);
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            tmo <= r[4:0];
            ext <= {r[23:0], r};
            apb(1'b1, OFS_ALT_EN, 32'h1f);
            nap(2);
            chk("cnt", {r[0], r[1], r[27], r[28]}, {o_wide_timer_count_in,
                o_wide_timer_capture_in, o_byte_timer_a_count_in, o_byte_timer_b_count_in});
            chk("alt", {8'h67, 1'b0, r[4:3], 2'b0, r[2:0]},
                {o_port_oe[PX_3] & 8'h67, o_port_pin[PX_3] & 8'h67});
            apb(1'b0, 8'h0c, 32'h0);
            chk("p3 pin", {1'b0, r[4:3], 2'b0, r[2:0]}, q[31:24] & 8'h67);
        end
        // Serial masters: data and clock pins driven, pin levels fed back
        apb(1'b1, OFS_ALT_EN, 32'h360);
        nap(2);
        chk("ser", {2'b11, sio[1:0], 2'b11, sio[5:4]}, {o_port_oe[PX_2][7:6],
            o_port_pin[PX_2][7:6], o_port_oe[PX_7][2:1], o_port_pin[PX_7][2:1]});
        chk("ser in", {sio[1], sio[5], sio[5], sio[0]}, {o_ser0_clock_pin_in,
            o_ser2_clock_pin_in, o_async_baud_clock_in, o_ser0_bus_line_b_in});
        $display("alternate test done");
        apb(1'b1, 8'h04, 32'h00ff0f00);
        apb(1'b1, OFS_ALT_EN, 32'h800);
        nap(1);
        chk("adc", {1'b1, 16'h0}, {o_analog_mode, o_port_oe[PX_1], o_port_pullup[PX_1]});
        // Only the segment select and interrupt registers are touched while converting
        r = rnd();
        i_lcd_segment_outputs <= {r[7:0], r};
        apb(1'b1, OFS_LCD_CTRL, 32'h11);
        nap(2);
        chk("lcd", {2'b11, r[30], r[31], 2'b11, r[6], r[7]}, {o_port_oe[PX_9][1:0],
            o_port_pin[PX_9][1:0], o_port_oe[PX_8][1:0], o_port_pin[PX_8][1:0]});
        $display("segment test done");
        ext[0] <= 8'h00;
        apb(1'b1, OFS_EDGE_CFG, 32'h1e4);
        apb(1'b1, OFS_IRQ_CLR, 32'h3f);
        apb(1'b1, OFS_IRQ_EN, 32'h3f);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_ref_clk);
            ext[0] <= (k == 0) ? 8'h3f : 8'h00;
            nap(6);
            chk("irq", 1'b1, o_irq);
            apb(1'b0, OFS_IRQ_STS, 32'h0);
            chk("sts", (k == 0) ? 6'h2d : 6'h1e, q[5:0]);
            apb(1'b1, OFS_IRQ_CLR, 32'h3f);
            nap(1);
            chk("irq clr", 1'b0, o_irq);
        end
        apb(1'b1, OFS_IRQ_STS, 32'h3f);
        apb(1'b0, OFS_IRQ_STS, 32'h0);
        chk("sts ro", 6'h00, q[5:0]);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", {1'b1, 32'h0}, {er, q});
        $display("interrupt test done");
        summarize();
    end
endmodule
